// ==== hw/sfdr_pkg.sv ====
// Constants, opcodes and state types of the serial flash command sequencer
package sfdr_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          ADDR_BITS      = 24;
  localparam int          SECTOR_LSB     = 12;
  localparam int          BLOCK_LSB      = 16;
  localparam int          PAGE_LSB       = 8;
  localparam int          PAGE_BYTES     = 256;
  localparam int          DUMMY_CLKS     = 8;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [4:0]  LAST_ADDR_BIT  = 5'h17;
  localparam logic [4:0]  LAST_BYTE_BIT  = 5'h07;
  localparam logic        WEL_RESET      = 1'b0;
  localparam logic [7:0]  OP_DUAL_READ   = 8'h3B;
  localparam logic [7:0]  OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0]  OP_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0]  OP_BLOCK_ERASE_B = 8'hD8;
  localparam logic [7:0]  OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0]  OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0]  OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0]  OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0]  OP_READ_STATUS = 8'h05;

  typedef enum logic [2:0] {
    SP_OPC   = 3'b000,
    SP_ADDR  = 3'b001,
    SP_DUMMY = 3'b011,
    SP_DOUT  = 3'b010,
    SP_PDATA = 3'b110,
    SP_SOUT  = 3'b111,
    SP_IGN   = 3'b101
  } sfdr_spi_e;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_FILL = 2'b01,
    EX_TIME = 2'b11
  } sfdr_exec_e;

  typedef enum logic [1:0] {
    ER_SECTOR = 2'b00,
    ER_BLOCK  = 2'b01,
    ER_CHIP   = 2'b10
  } sfdr_erase_e;
endpackage

// ==== hw/sfdr_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sfdr_fifo #(
  parameter int W     = 29,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wrPtr_r;
  logic [PW:0]  rdPtr_r;

  wire empty = (wrPtr_r == rdPtr_r);
  wire full  = (wrPtr_r[PW-1:0] == rdPtr_r[PW-1:0]) && (wrPtr_r[PW] != rdPtr_r[PW]);
  wire push  = inValid && !full;
  wire pop   = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_r[PW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wrPtr_r[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + (PW+1)'(push);
      rdPtr_r <= rdPtr_r + (PW+1)'(pop);
    end
  end
endmodule // sfdr_fifo

// ==== hw/sfdr_flash_seq.sv ====
// Serial flash command sequencer: dual read, erases and page program
`timescale 1ns/1ps
module sfdr_flash_seq
  import sfdr_pkg::*;
#(
  parameter int unsigned ADDR_W                 = 21,
  parameter int unsigned SECTOR_ERASE_TIME_US   = 1000,
  parameter int unsigned BLOCK_ERASE_TIME_US    = 2000,
  parameter int unsigned CHIP_ERASE_TIME_US     = 8000,
  parameter int unsigned PAGE_PROGRAM_TIME_US   = 100,
  parameter int unsigned SECTOR_ERASE_CYC       = SECTOR_ERASE_TIME_US * CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYC        = BLOCK_ERASE_TIME_US * CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYC         = CHIP_ERASE_TIME_US * CLK_MHZ,
  parameter int unsigned PAGE_PROGRAM_CYC       = PAGE_PROGRAM_TIME_US * CLK_MHZ
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              csN,
  input  wire logic              sclk,
  input  wire logic              dataLineLowIn,
  output logic                   dataLineLowOut,
  output logic                   dataLineLowOe,
  output logic                   dataLineHighOut,
  output logic                   dataLineHighOe,
  input  wire logic [3:0]        protectLevelBits,
  output logic                   writeEnableLatch,
  output logic                   writeInProgress,
  output logic [ADDR_W-1:0]      memRdAddr,
  input  wire logic [7:0]        memRdData,
  output logic                   eraseStrobe,
  output sfdr_erase_e            eraseKind,
  output logic [ADDR_W-1:0]      eraseAddr,
  output logic                   progValid,
  input  wire logic              progReady,
  output logic [ADDR_W-1:0]      progAddr,
  output logic [7:0]             progData
);
  localparam int NUM_BLOCKS  = 1 << (ADDR_W - BLOCK_LSB);
  localparam int FULL_LEVEL  = ADDR_W - BLOCK_LSB + 1;
  localparam int FW          = ADDR_W + 8;

  // Upper 2^(level-1) blocks are protected; the top level protects everything
  function automatic logic protectedAt(input logic [ADDR_W-1:0] a, input logic [3:0] bp);
    int blk;
    blk = int'(a[ADDR_W-1:BLOCK_LSB]);
    if (bp == 4'h0)
      return 1'b0;
    else if (int'(bp) >= FULL_LEVEL)
      return 1'b1;
    else
      return blk >= (NUM_BLOCKS - (1 << (int'(bp) - 1)));
  endfunction

  sfdr_spi_e             state_r;
  sfdr_exec_e            exec_r;
  logic                  sclkQ_r;
  logic                  csQ_r;
  logic [4:0]            bitCnt_r;
  logic [7:0]            opcode_r;
  logic [ADDR_BITS-1:0]  cmdAddr_r;
  logic                  atBoundary_r;
  logic [7:0]            curByte_r;
  logic [2:0]            outIdx_r;
  logic [ADDR_W-1:0]     readAddr_r;
  logic [7:0]            pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask_r;
  logic [7:0]            ptr_r;
  logic                  gotByte_r;
  logic [7:0]            fillIdx_r;
  logic [31:0]           tmr_r;
  logic                  wel_r;
  logic                  eraseStrobe_r;
  sfdr_erase_e           eraseKind_r;
  logic [ADDR_W-1:0]     eraseAddr_r;
  logic                  fifoInReady;
  logic [FW-1:0]         fifoOut;

  wire sclkRise = sclk && !sclkQ_r && !csN;
  wire sclkFall = !sclk && sclkQ_r && !csN;
  wire csRise   = csN && !csQ_r;
  wire busy     = (exec_r != EX_IDLE);
  wire [7:0] shNext = {cmdAddr_r[6:0], dataLineLowIn};
  wire [ADDR_BITS-1:0] addrNext = {cmdAddr_r[ADDR_BITS-2:0], dataLineLowIn};
  wire byteDone = sclkRise && (bitCnt_r == LAST_BYTE_BIT);
  wire addrDone = sclkRise && (state_r == SP_ADDR) && (bitCnt_r == LAST_ADDR_BIT);
  wire dummyDone = sclkRise && (state_r == SP_DUMMY) && (bitCnt_r == 5'(DUMMY_CLKS - 1));
  wire [ADDR_W-1:0] tgtAddr = readAddr_r;   // Held from the address phase; data shifts past it
  wire tgtProt  = protectedAt(tgtAddr, protectLevelBits);
  wire opIsBe   = (opcode_r == OP_BLOCK_ERASE_A) || (opcode_r == OP_BLOCK_ERASE_B);
  wire opIsCe   = (opcode_r == OP_CHIP_ERASE_A) || (opcode_r == OP_CHIP_ERASE_B);
  wire cmdEnd   = csRise && atBoundary_r && !busy;
  wire startSe  = cmdEnd && wel_r && (opcode_r == OP_SECTOR_ERASE) && !tgtProt;
  wire startBe  = cmdEnd && wel_r && opIsBe && !tgtProt;
  wire startCe  = cmdEnd && wel_r && opIsCe && (protectLevelBits == 4'h0);
  wire startPp  = csRise && !busy && wel_r && (state_r == SP_PDATA)
                  && gotByte_r && !tgtProt;
  wire wrenHit  = cmdEnd && (opcode_r == OP_WRITE_ENABLE);
  wire fillPush = (exec_r == EX_FILL) && mask_r[fillIdx_r];
  wire fillStep = !mask_r[fillIdx_r] || fifoInReady;
  wire execDone = (exec_r == EX_TIME) && (tmr_r == 32'h0000_0000) && !progValid;
  wire [7:0] statusByte = {2'b00, protectLevelBits, wel_r, busy};

  assign writeEnableLatch = wel_r;
  assign writeInProgress  = busy;
  assign memRdAddr        = readAddr_r;
  assign dataLineLowOe    = !csN && (state_r == SP_DOUT);
  assign dataLineHighOe   = !csN && ((state_r == SP_DOUT) || (state_r == SP_SOUT));
  assign eraseStrobe      = eraseStrobe_r;
  assign eraseKind        = eraseKind_r;
  assign eraseAddr        = eraseAddr_r;
  assign progAddr         = fifoOut[FW-1:8];
  assign progData         = fifoOut[7:0];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclkQ_r <= 1'b0;
      csQ_r   <= 1'b1;
    end
    else
    begin
      sclkQ_r <= sclk;
      csQ_r   <= csN;
    end
  end

  // Serial command front end, advanced on each rising serial clock
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= SP_OPC;
      bitCnt_r     <= 5'h00;
      opcode_r     <= 8'h00;
      cmdAddr_r    <= '0;
      atBoundary_r <= 1'b0;
    end
    else if (csN)
    begin
      state_r      <= SP_OPC;
      bitCnt_r     <= 5'h00;
      atBoundary_r <= 1'b0;
    end
    else if (sclkRise)
    begin
      bitCnt_r     <= bitCnt_r + 5'h01;
      cmdAddr_r    <= addrNext;
      atBoundary_r <= 1'b0;
      case (state_r)
        SP_OPC:
        begin
          if (byteDone)
          begin
            opcode_r <= shNext;
            bitCnt_r <= 5'h00;
            if (busy && shNext != OP_READ_STATUS)
              state_r <= SP_IGN;
            else if (shNext == OP_READ_STATUS)
              state_r <= SP_SOUT;
            else if (shNext == OP_DUAL_READ || shNext == OP_SECTOR_ERASE ||
                     shNext == OP_BLOCK_ERASE_A || shNext == OP_BLOCK_ERASE_B ||
                     shNext == OP_PAGE_PROGRAM)
              state_r <= SP_ADDR;
            else
            begin
              atBoundary_r <= 1'b1;
              state_r      <= SP_IGN;
            end
          end
        end
        SP_ADDR:
        begin
          if (addrDone)
          begin
            bitCnt_r <= 5'h00;
            if (opcode_r == OP_DUAL_READ)
              state_r <= SP_DUMMY;
            else if (opcode_r == OP_PAGE_PROGRAM)
              state_r <= SP_PDATA;
            else
            begin
              atBoundary_r <= 1'b1;
              state_r      <= SP_IGN;
            end
          end
        end
        SP_DUMMY:
        begin
          if (dummyDone)
          begin
            bitCnt_r <= 5'h00;
            state_r  <= SP_DOUT;
          end
        end
        SP_PDATA:
        begin
          if (byteDone)
            bitCnt_r <= 5'h00;
        end
        default:
        begin
          bitCnt_r <= 5'h00;
        end
      endcase
    end
  end

  // Output shifter: bit pairs for dual read, single bits for status
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      curByte_r       <= 8'h00;
      outIdx_r        <= 3'h0;
      readAddr_r      <= '0;
      dataLineLowOut  <= 1'b0;
      dataLineHighOut <= 1'b0;
    end
    else if (addrDone)
    begin
      readAddr_r <= addrNext[ADDR_W-1:0];
    end
    else if (dummyDone)
    begin
      curByte_r <= memRdData;
      outIdx_r  <= 3'h0;
    end
    else if (byteDone && state_r == SP_OPC)
    begin
      curByte_r <= statusByte;
      outIdx_r  <= 3'h0;
    end
    else if (sclkFall && state_r == SP_DOUT)
    begin
      dataLineHighOut <= curByte_r[7];
      dataLineLowOut  <= curByte_r[6];
      outIdx_r        <= {1'b0, outIdx_r[1:0] + 2'h1};
      if (outIdx_r[1:0] == 2'h0)
        readAddr_r <= readAddr_r + 1'b1;
      if (outIdx_r[1:0] == 2'h3)
        curByte_r <= memRdData;
      else
        curByte_r <= {curByte_r[5:0], 2'b00};
    end
    else if (sclkFall && state_r == SP_SOUT)
    begin
      dataLineHighOut <= curByte_r[7];
      outIdx_r        <= outIdx_r + 3'h1;
      if (outIdx_r == 3'h7)
        curByte_r <= statusByte;
      else
        curByte_r <= {curByte_r[6:0], 1'b0};
    end
  end

  // Page buffer: ring of one page, newest byte wins per position
  always_ff @(posedge core_clk)
  begin
    if (byteDone && state_r == SP_PDATA && !busy)
      pageBuf[ptr_r] <= shNext;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_r    <= '0;
      ptr_r     <= 8'h00;
      gotByte_r <= 1'b0;
    end
    else if (addrDone && opcode_r == OP_PAGE_PROGRAM)
    begin
      ptr_r     <= addrNext[PAGE_LSB-1:0];
      mask_r    <= '0;
      gotByte_r <= 1'b0;
    end
    else if (byteDone && state_r == SP_PDATA && !busy)
    begin
      mask_r[ptr_r] <= 1'b1;
      ptr_r         <= ptr_r + 8'h01;
      gotByte_r     <= 1'b1;
    end
  end

  // Self-timed execution of program and erase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exec_r    <= EX_IDLE;
      fillIdx_r <= 8'h00;
      tmr_r     <= 32'h0000_0000;
    end
    else
    begin
      if (tmr_r != 32'h0000_0000)
        tmr_r <= tmr_r - 32'h0000_0001;
      case (exec_r)
        EX_IDLE:
        begin
          fillIdx_r <= 8'h00;
          if (startPp)
          begin
            exec_r <= EX_FILL;
            tmr_r  <= 32'(PAGE_PROGRAM_CYC);
          end
          else if (startSe || startBe || startCe)
          begin
            exec_r <= EX_TIME;
            tmr_r  <= startSe ? 32'(SECTOR_ERASE_CYC) :
                      startBe ? 32'(BLOCK_ERASE_CYC) : 32'(CHIP_ERASE_CYC);
          end
        end
        EX_FILL:
        begin
          if (fillStep)
          begin
            fillIdx_r <= fillIdx_r + 8'h01;
            if (fillIdx_r == 8'hFF)
              exec_r <= EX_TIME;
          end
        end
        EX_TIME:
        begin
          if (execDone)
            exec_r <= EX_IDLE;
        end
        default:
        begin
          exec_r <= EX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wel_r         <= WEL_RESET;
      eraseStrobe_r <= 1'b0;
      eraseKind_r   <= ER_SECTOR;
      eraseAddr_r   <= '0;
    end
    else
    begin
      if (wrenHit)
        wel_r <= 1'b1;
      else if (execDone)
        wel_r <= 1'b0;
      eraseStrobe_r <= startSe || startBe || startCe;
      if (startSe)
      begin
        eraseKind_r <= ER_SECTOR;
        eraseAddr_r <= {tgtAddr[ADDR_W-1:SECTOR_LSB], SECTOR_LSB'(0)};
      end
      else if (startBe)
      begin
        eraseKind_r <= ER_BLOCK;
        eraseAddr_r <= {tgtAddr[ADDR_W-1:BLOCK_LSB], BLOCK_LSB'(0)};
      end
      else if (startCe)
      begin
        eraseKind_r <= ER_CHIP;
        eraseAddr_r <= '0;
      end
    end
  end

  // Program bytes queue toward the array; the array may stall them
  sfdr_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (fillPush),
    .inReady  (fifoInReady),
    .inData   ({tgtAddr[ADDR_W-1:PAGE_LSB], fillIdx_r, pageBuf[fillIdx_r]}),
    .outValid (progValid),
    .outReady (progReady),
    .outData  (fifoOut)
  );
endmodule // sfdr_flash_seq

// ==== dv/sfdr_flash_seq_monitor.sv ====
// Port-level assertions for the flash command sequencer
`timescale 1ns/1ps
module sfdr_flash_seq_monitor
  import sfdr_pkg::*;
#(
  parameter int unsigned ADDR_W = 21
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              csN,
  input wire logic              dataLineLowOe,
  input wire logic              dataLineHighOe,
  input wire logic [3:0]        protectLevelBits,
  input wire logic              writeEnableLatch,
  input wire logic              writeInProgress,
  input wire logic              eraseStrobe,
  input wire sfdr_erase_e       eraseKind,
  input wire logic [ADDR_W-1:0] eraseAddr,
  input wire logic              progValid,
  input wire logic              progReady,
  input wire logic [ADDR_W-1:0] progAddr,
  input wire logic [7:0]        progData
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  oe_needs_select_a: assert property (csN |-> !dataLineLowOe && !dataLineHighOe)
    else $error("output enable while deselected");
  dual_pair_lines_a: assert property (dataLineLowOe |-> dataLineHighOe)
    else $error("low line driven without high line");
  strobe_needs_wel_a: assert property (
    eraseStrobe |-> writeEnableLatch && writeInProgress)
    else $error("erase started without latch or busy flag");
  strobe_single_a: assert property (eraseStrobe |=> !eraseStrobe)
    else $error("erase start longer than one cycle");
  no_start_busy_a: assert property (eraseStrobe |-> !$past(writeInProgress))
    else $error("erase started while busy");
  wel_clears_end_a: assert property ($fell(writeInProgress) |-> !writeEnableLatch)
    else $error("latch still set after busy ends");
  chip_unprotected_a: assert property (
    eraseStrobe && eraseKind == ER_CHIP |-> protectLevelBits == 4'h0 && eraseAddr == '0)
    else $error("chip erase under protection");
  erase_aligned_a: assert property (
    eraseStrobe && eraseKind != ER_CHIP |-> eraseAddr[11:0] == 12'h000
    && (eraseKind == ER_SECTOR || eraseAddr[15:12] == 4'h0))
    else $error("erase base not aligned");
  prog_holds_a: assert property (
    progValid && !progReady |=> progValid && $stable(progAddr) && $stable(progData))
    else $error("program byte dropped while stalled");
  dual_not_busy_a: assert property ($rose(dataLineLowOe) |-> !writeInProgress)
    else $error("dual output while busy");
  cover property (eraseStrobe && eraseKind == ER_SECTOR);
  cover property (eraseStrobe && eraseKind == ER_CHIP);
  cover property (progValid && !progReady);
  cover property ($rose(dataLineLowOe));
endmodule // sfdr_flash_seq_monitor

bind sfdr_flash_seq sfdr_flash_seq_monitor #(.ADDR_W(ADDR_W)) monitor (
  .core_clk(core_clk), .rst_n(rst_n), .csN(csN), .dataLineLowOe(dataLineLowOe),
  .dataLineHighOe(dataLineHighOe), .protectLevelBits(protectLevelBits),
  .writeEnableLatch(writeEnableLatch), .writeInProgress(writeInProgress),
  .eraseStrobe(eraseStrobe), .eraseKind(eraseKind), .eraseAddr(eraseAddr),
  .progValid(progValid), .progReady(progReady), .progAddr(progAddr), .progData(progData));

// ==== dv/sfdr_host_model.sv ====
// Host serial controller model: select, serial clock and input line
`timescale 1ns/1ps
module sfdr_host_model (
  input  wire logic core_clk,
  output logic      csN,
  output logic      sclk,
  output logic      hostLow,
  input  wire logic highLine,
  input  wire logic lowLine
);
  logic [1:0] pairs[$];
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    hostLow = 1'b0;
  end
  task automatic waitCyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Clock high held three cycles, low six between bits; both lines captured after every fall
  task automatic sendBits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      hostLow = v[i];
      waitCyc(3);
      sclk = 1'b1;
      waitCyc(3);
      sclk = 1'b0;
      waitCyc(3);
      pairs.push_back({highLine, lowLine});
    end
  endtask
  task automatic select();
    pairs.delete();
    csN = 1'b0;
    waitCyc(2);
  endtask
  // Released input line flips so a stale level never looks valid
  task automatic deselect();
    csN = 1'b1;
    hostLow = ~hostLow;
    waitCyc(4);
  endtask
endmodule // sfdr_host_model

// ==== dv/sfdr_flash_seq_tb.sv ====
// Self-checking testbench of the flash command sequencer
`timescale 1ns/1ps
module sfdr_flash_seq_tb;
  import sfdr_pkg::*;
  localparam int unsigned AW = 21;
  logic core_clk, rst_n, csN, sclk, hostLow, lowLine, highLine, progReady, progValid;
  logic dataLineLowOut, dataLineLowOe, dataLineHighOut, dataLineHighOe, eraseStrobe;
  logic writeEnableLatch, writeInProgress, oeSeen;
  logic [3:0] protectLevelBits;
  logic [7:0] memRdData, progData;
  logic [AW-1:0] memRdAddr, eraseAddr, progAddr;
  sfdr_erase_e eraseKind;
  logic [AW+1:0] strobes[$];
  logic [AW+7:0] progQ[$];
  logic [31:0] rngState;
  logic [7:0] ops[5] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B,
                         OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  assign lowLine = dataLineLowOe ? dataLineLowOut : hostLow;
  assign highLine = dataLineHighOe ? dataLineHighOut : ~dataLineHighOut;
  sfdr_host_model host (.core_clk(core_clk), .csN(csN), .sclk(sclk), .hostLow(hostLow),
    .highLine(highLine), .lowLine(lowLine));
  sfdr_flash_seq #(.ADDR_W(AW), .SECTOR_ERASE_CYC(2000), .BLOCK_ERASE_CYC(2000),
    .CHIP_ERASE_CYC(2000), .PAGE_PROGRAM_CYC(200)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .dataLineLowIn(lowLine),
    .dataLineLowOut(dataLineLowOut), .dataLineLowOe(dataLineLowOe),
    .dataLineHighOut(dataLineHighOut), .dataLineHighOe(dataLineHighOe),
    .protectLevelBits(protectLevelBits), .writeEnableLatch(writeEnableLatch),
    .writeInProgress(writeInProgress), .memRdAddr(memRdAddr), .memRdData(memRdData),
    .eraseStrobe(eraseStrobe), .eraseKind(eraseKind), .eraseAddr(eraseAddr),
    .progValid(progValid), .progReady(progReady), .progAddr(progAddr), .progData(progData));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xorshift();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction
  function automatic logic [7:0] arrayByte(input logic [AW-1:0] a);
    return a[7:0] ^ a[15:8] ^ {3'b000, a[20:16]} ^ 8'h3c;
  endfunction
  function automatic logic isProt(input logic [AW-1:0] a);
    int l;
    l = int'(protectLevelBits);
    if (l == 0)
      return 1'b0;
    return l >= 6 || int'(a[AW-1:16]) >= 32 - (1 << (l - 1));
  endfunction
  always @(posedge core_clk)
  begin
    memRdData <= arrayByte(memRdAddr);
    if (dataLineLowOe === 1'b1)
      oeSeen = 1'b1;
    if (eraseStrobe === 1'b1)
      strobes.push_back({eraseKind, eraseAddr});
    if (progValid === 1'b1 && progReady === 1'b1)
      progQ.push_back({progAddr, progData});
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      complete_run();
    end
  end
  // Array side stalls about a quarter of the time
  always @(negedge core_clk)
    if (rst_n)
      progReady = (xorshift() & 32'h0000_0003) != 32'h0000_0000;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    while (writeInProgress !== 1'b0 && n < 30000)
    begin
      @(negedge core_clk);
      n++;
    end
    check(64'(n == 30000), 64'h0);
  endtask
  task automatic write_enable_cmd();
    host.select();
    host.sendBits(32'(OP_WRITE_ENABLE), 8);
    host.deselect();
    check(64'(writeEnableLatch), 64'h1);
  endtask
  task automatic dualRead(input logic [AW-1:0] a, input logic live);
    logic [23:0] seen;
    logic [AW-1:0] b;
    host.select();
    host.sendBits({OP_DUAL_READ, 3'b000, a}, 32);
    host.sendBits(32'h0000_0000, 20);
    host.deselect();
    for (int i = 0; i < 12; i++)
      seen = {seen[21:0], host.pairs[39 + i]};
    b = a + 1'b1;
    if (live)
      check(64'(seen), 64'({arrayByte(a), arrayByte(b), arrayByte(b + 1'b1)}));
  endtask
  task automatic eraseCase(input logic [7:0] op, input logic [AW-1:0] a, input int abits,
                           input logic we);
    logic chip, ok;
    logic [AW+1:0] exp;
    logic [7:0] st;
    chip = op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B;
    ok = we && abits == (chip ? 0 : 24) && (chip ? protectLevelBits == 4'h0 : !isProt(a));
    exp = chip ? {ER_CHIP, {AW{1'b0}}} : op == OP_SECTOR_ERASE ?
      {ER_SECTOR, a[AW-1:12], 12'h000} : {ER_BLOCK, a[AW-1:16], 16'h0000};
    if (we)
      write_enable_cmd();
    strobes.delete();
    oeSeen = 1'b0;
    host.select();
    host.sendBits(32'(op), 8);
    host.sendBits(32'(a), abits);
    host.deselect();
    if (ok)
    begin
      host.select();
      host.sendBits(32'(OP_READ_STATUS) << 8, 16);
      host.deselect();
      for (int i = 7; i < 15; i++)
        st = {st[6:0], host.pairs[i][1]};
      check(64'(st), 64'({2'b00, protectLevelBits, 2'b11}));
      dualRead(a, 1'b0);
      check(64'(oeSeen), 64'h0);
    end
    waitIdle();
    check(64'(strobes.size()), 64'(ok));
    if (ok)
      check(64'(strobes[0]), 64'(exp));
    check(64'(writeEnableLatch), 64'(we && !ok));
  endtask
  task automatic progCase(input logic [AW-1:0] a, input int n);
    logic [8:0] pb[256];
    logic [7:0] d;
    logic [AW+7:0] expQ[$];
    foreach (pb[i])
      pb[i] = 9'h000;
    write_enable_cmd();
    progQ.delete();
    host.select();
    host.sendBits({OP_PAGE_PROGRAM, 3'b000, a}, 32);
    for (int k = 0; k < n; k++)
    begin
      d = 8'(xorshift());
      host.sendBits(32'(d), 8);
      pb[8'(a[7:0] + k)] = {1'b1, d};
    end
    host.deselect();
    waitIdle();
    for (int i = 0; i < 256; i++)
      if (pb[i][8] && !isProt(a))
        expQ.push_back({a[AW-1:8], 8'(i), pb[i][7:0]});
    check(64'(progQ.size()), 64'(expQ.size()));
    foreach (expQ[i])
      if (i < progQ.size())
        check(64'(progQ[i]), 64'(expQ[i]));
    check(64'(writeEnableLatch), 64'(isProt(a)));
  endtask
  initial
  begin
    rngState = 32'h0000_7c49;
    rst_n = 1'b0;
    protectLevelBits = 4'h0;
    progReady = 1'b0;
    memRdData = 8'h00;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check(64'({writeEnableLatch, writeInProgress}), 64'h0);
    eraseCase(OP_SECTOR_ERASE, 21'h00_1234, 24, 1'b0);
    eraseCase(OP_BLOCK_ERASE_A, 21'h01_0000, 25, 1'b1);
    eraseCase(OP_CHIP_ERASE_B, 21'h00_0000, 8, 1'b1);
    $display("boundary tests done");
    for (int p = 0; p < 2; p++)
    begin
      protectLevelBits = p ? 4'h2 : 4'h0;
      for (int j = 0; j < 5; j++)
        eraseCase(ops[j], 21'(xorshift()) | (j != 2 ? 21'h1E_0000 : 21'h00_0000),
                  j < 3 ? 24 : 0, 1'b1);
    end
    $display("erase tests done");
    protectLevelBits = 4'h0;
    progCase(21'h00_A5F0, 20);
    progCase(21'h03_2010, 260);
    protectLevelBits = 4'h2;
    progCase(21'h1F_0040, 5);
    protectLevelBits = 4'h0;
    $display("program tests done");
    dualRead(21'h1F_FFFE, 1'b1);
    dualRead(21'(xorshift()), 1'b1);
    $display("read tests done");
    complete_run();
  end
endmodule // sfdr_flash_seq_tb
